//--- hw/rx_frame_pkg.sv
package rx_frame_pkg;

  // ----------------------------------------------------------------
  // Word kinds, states and classes
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    data_word         = 4'b0000,
    idle_start_word   = 4'b0001,
    data_start_word   = 4'b0010,
    bcast_start_word  = 4'b0011,
    data_end_word     = 4'b0100,
    bcast_end_word    = 4'b0101,
    flow_credit_token = 4'b0110,
    ack_word          = 4'b0111,
    nack_word         = 4'b1000,
    full_word         = 4'b1001,
    retry_word        = 4'b1010,
    other_word        = 4'b1011
  } word_kind_t;

  typedef enum logic [2:0] {
    st_nothing_rx    = 3'b000,
    st_idle_frame    = 3'b001,
    st_data_frame    = 3'b010,
    st_bcast_frame   = 3'b011,
    st_bcast_in_data = 3'b100
  } rx_state_t;

  typedef enum logic [1:0] {
    cls_none  = 2'b00,
    cls_idle  = 2'b01,
    cls_data  = 2'b10,
    cls_bcast = 2'b11
  } word_class_t;

  // ----------------------------------------------------------------
  // Sizes, field positions and checksum constants
  // ----------------------------------------------------------------
  localparam int          DBUF_DEPTH   = 64;
  localparam int          DBUF_AW      = 6;
  localparam logic [1:0]  BC_WORDS     = 2'h2;
  localparam logic [1:0]  BC_CNT_MAX   = 2'h3;
  localparam logic [5:0]  COVER_WORD   = 6'h20;
  localparam logic [5:0]  COVER_EDF    = 6'h10;
  localparam logic [5:0]  COVER_CTRL   = 6'h18;
  localparam int          EDF_CRC_LSB  = 16;
  localparam int          CTRL_CRC_LSB = 24;
  localparam logic [15:0] CRC16_INIT   = 16'hFFFF;
  localparam logic [15:0] CRC16_POLY   = 16'h1021;
  localparam logic [7:0]  CRC8_INIT    = 8'h00;
  localparam logic [7:0]  CRC8_POLY    = 8'h07;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        valid;
    word_kind_t  kind;
    logic [31:0] word;
  } lane_word_t;

  typedef struct packed {
    logic        valid;
    logic        last;
    logic [31:0] word;
  } df_out_t;

  typedef struct packed {
    logic            valid;
    logic [1:0][31:0] words;
  } bc_out_t;

  typedef struct packed {
    logic        valid;
    word_kind_t  kind;
    logic [31:0] word;
  } ctrl_out_t;

  typedef struct packed {
    logic        valid;
    word_class_t cls;
  } class_out_t;

  // ----------------------------------------------------------------
  // Checksum steps, bit 0 of byte 0 entered first
  // ----------------------------------------------------------------
  function automatic logic [15:0] crc16_upd(input logic [15:0] c,
      input logic [31:0] d, input logic [5:0] nbits);
    logic [15:0] r;
    logic        fb;
    r = c;
    for (int i = 0; i < 32; i++)
    begin
      fb = r[15] ^ d[i];
      if (i < int'(nbits))
        r = {r[14:0], 1'b0} ^ (fb ? CRC16_POLY : 16'h0000);
    end
    return r;
  endfunction

  function automatic logic [7:0] crc8_upd(input logic [7:0] c,
      input logic [31:0] d, input logic [5:0] nbits);
    logic [7:0] r;
    logic       fb;
    r = c;
    for (int i = 0; i < 32; i++)
    begin
      fb = r[7] ^ d[i];
      if (i < int'(nbits))
        r = {r[6:0], 1'b0} ^ (fb ? CRC8_POLY : 8'h00);
    end
    return r;
  endfunction

  function automatic logic [7:0] bit_rev8(input logic [7:0] r);
    logic [7:0] b;
    for (int i = 0; i < 8; i++)
      b[i] = r[7-i];
    return b;
  endfunction

endpackage

//--- hw/crc16_acc.sv
`timescale 1ns/100ps
// Running 16-bit frame checksum; start restarts from the preset value
module crc16_acc
  import rx_frame_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        start,
  input  wire logic        en,
  input  wire logic [5:0]  nbits,
  input  wire logic [31:0] data,
  output wire logic [15:0] crc_nxt
);

  logic [15:0] crc_q;
  logic [15:0] base;

  // Start word seeds the sum in the same cycle it is added
  assign base    = start ? CRC16_INIT : crc_q;
  assign crc_nxt = crc16_upd(base, data, nbits);

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      crc_q <= CRC16_INIT;
    else if (en)
      crc_q <= crc_nxt;
  end

endmodule

//--- hw/crc8_acc.sv
`timescale 1ns/100ps
// Running 8-bit broadcast checksum, Galois shift register preset to zero
module crc8_acc
  import rx_frame_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        start,
  input  wire logic        en,
  input  wire logic [5:0]  nbits,
  input  wire logic [31:0] data,
  output wire logic [7:0]  crc_nxt
);

  logic [7:0] crc_q;
  logic [7:0] base;

  assign base    = start ? CRC8_INIT : crc_q;
  assign crc_nxt = crc8_upd(base, data, nbits);

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      crc_q <= CRC8_INIT;
    else if (en)
      crc_q <= crc_nxt;
  end

endmodule

//--- hw/rx_frame_check_crc.sv
`timescale 1ns/100ps
// Function
// - From nothing, idle start enters idle state; data words flagged idle.
// - Idle state exits first on retry, then lane error, to nothing.
// - End word in idle state is a frame error, to nothing; third priority.
// - Idle: broadcast start, data start, idle start lead to their states.
// - Credit, ack, nack, full and retry words accepted in any state.
// - Frame words held in a buffer until checks pass.
// - Only error-free, in-sequence frames and credit tokens go upward; ack, nack, full and retry words also go up here.
// - Data buffer fills in data state; broadcast buffer in broadcast states.
// - Data start flushes data buffer; broadcast start flushes its buffer.
// - Entering nothing state flushes both buffers.
// - Clean data end word hands the buffered frame upward.
// - Broadcast handed up only on clean end word with exactly two words.
// - Cold reset, warm reset or remote flush empty both buffers.
// - Data checksum spans start-word comma to end-word sequence field.
// - Control codes inside coverage enter the checksum as data values.
// - Packet end, error end and fill codes enter the data checksum.
// - Data checksum is CRC-16-CCITT, low bit of low byte first.
// - 8-bit checksum guards broadcasts, tokens, full, ack and nack words.
// - 8-bit checksum: generator x^8+x^2+x+1, zero-preset shift register.
// - 8-bit input: bytes in order, each entered low bit first.
// - 8-bit checksum byte is the bit-reversed remainder.
// - Checker compares regenerated checksum against received byte.
// - Checksum error in data state sends machine to nothing.
// - Broadcast end with count two in nested state returns to data.
module rx_frame_check_crc
  import rx_frame_pkg::*;
(
  input  wire logic   clk,
  input  wire logic   sys_rst,
  input  lane_word_t  rx_in,
  input  wire logic   lane_rx_error,
  input  wire logic   seq_ok,
  input  wire logic   warm_reset_req,
  input  wire logic   remote_flush_req,
  output df_out_t     df_out,
  output bc_out_t     bc_out,
  output ctrl_out_t   ctrl_out,
  output class_out_t  class_out,
  output logic        crc_err_pulse,
  output logic        frame_err_pulse,
  output rx_state_t   rx_state
);

  // ----------------------------------------------------------------
  // Word decode
  // ----------------------------------------------------------------
  rx_state_t   st_q;
  rx_state_t   st_d;
  logic        v_data;
  logic        v_sif;
  logic        v_sdf;
  logic        v_sbf;
  logic        v_edf;
  logic        v_ebf;
  logic        v_retry;
  logic        in_dframe;
  logic        in_bframe;
  logic        flush_req;
  logic        enter_nothing;

  assign v_data    = rx_in.valid && (rx_in.kind == data_word);
  assign v_sif     = rx_in.valid && (rx_in.kind == idle_start_word);
  assign v_sdf     = rx_in.valid && (rx_in.kind == data_start_word);
  assign v_sbf     = rx_in.valid && (rx_in.kind == bcast_start_word);
  assign v_edf     = rx_in.valid && (rx_in.kind == data_end_word);
  assign v_ebf     = rx_in.valid && (rx_in.kind == bcast_end_word);
  assign v_retry   = rx_in.valid && (rx_in.kind == retry_word);
  assign in_dframe = (st_q == st_data_frame);
  assign in_bframe = (st_q == st_bcast_frame) ||
                     (st_q == st_bcast_in_data);
  // Cold reset is sys_rst itself
  assign flush_req = warm_reset_req || remote_flush_req;
  assign enter_nothing = (st_d == st_nothing_rx) &&
                         (st_q != st_nothing_rx);

  // ----------------------------------------------------------------
  // Checksums
  // ----------------------------------------------------------------
  // A comma and its data twin share one byte value, so feeding the raw
  // byte with the control flag dropped gives the data value
  logic [15:0] crc16_nxt;
  logic [7:0]  crc8_nxt;
  logic        d_crc_bad;
  logic        b_crc_bad;
  logic        crc_bad;
  logic        seq_bad;
  logic        end_hit;
  logic        abort;
  logic        ctrl_crc_ok;

  crc16_acc u_crc16 (
    .clk     (clk),
    .sys_rst (sys_rst),
    .start   (v_sdf),
    .en      (v_sdf || (in_dframe && v_data)),
    .nbits   (v_edf ? COVER_EDF : COVER_WORD),
    .data    (rx_in.word),
    .crc_nxt (crc16_nxt)
  );

  crc8_acc u_crc8 (
    .clk     (clk),
    .sys_rst (sys_rst),
    .start   (v_sbf),
    .en      (v_sbf || (in_bframe && v_data)),
    .nbits   (v_ebf ? COVER_CTRL : COVER_WORD),
    .data    (rx_in.word),
    .crc_nxt (crc8_nxt)
  );

  // Regenerate and compare against the received field
  assign d_crc_bad = in_dframe && v_edf &&
                     (crc16_nxt != rx_in.word[31:EDF_CRC_LSB]);
  assign b_crc_bad = in_bframe && v_ebf &&
                     (bit_rev8(crc8_nxt) !=
                      rx_in.word[31:CTRL_CRC_LSB]);
  assign crc_bad   = d_crc_bad || b_crc_bad;
  assign end_hit   = (in_dframe && v_edf) || (in_bframe && v_ebf);
  assign seq_bad   = end_hit && !crc_bad && !seq_ok;
  assign abort     = v_retry || lane_rx_error || crc_bad || seq_bad;
  // Stand-alone control words carry their own 8-bit check
  assign ctrl_crc_ok = bit_rev8(crc8_upd(CRC8_INIT, rx_in.word,
                       COVER_CTRL)) == rx_in.word[31:CTRL_CRC_LSB];

  // ----------------------------------------------------------------
  // Word identification machine
  // ----------------------------------------------------------------
  logic       ferr_d;
  logic [1:0] bcnt_q;

  // Exits are tested in priority order; a flush overrides all
  always_comb
  begin
    st_d   = st_q;
    ferr_d = 1'b0;
    case (st_q)
      st_nothing_rx:
        if (v_sbf)
          st_d = st_bcast_frame;
        else if (v_sdf)
          st_d = st_data_frame;
        else if (v_sif)
          st_d = st_idle_frame;
      st_idle_frame:
        if (v_retry || lane_rx_error)
          st_d = st_nothing_rx;
        else if (v_edf || v_ebf)
        begin
          st_d   = st_nothing_rx;
          ferr_d = 1'b1;
        end
        else if (v_sbf)
          st_d = st_bcast_frame;
        else if (v_sdf)
          st_d = st_data_frame;
      st_data_frame:
        if (abort)
          st_d = st_nothing_rx;
        else if (v_sbf)
          st_d = st_bcast_in_data;
        else if (v_edf)
          st_d = st_nothing_rx;
        else if (v_sdf || v_sif || v_ebf)
        begin
          st_d   = st_nothing_rx;
          ferr_d = 1'b1;
        end
      st_bcast_frame:
        if (abort || v_ebf)
          st_d = st_nothing_rx;
        else if (v_sdf || v_sbf || v_sif || v_edf)
        begin
          st_d   = st_nothing_rx;
          ferr_d = 1'b1;
        end
      st_bcast_in_data:
        if (abort)
          st_d = st_nothing_rx;
        else if (v_ebf)
          st_d = (bcnt_q == BC_WORDS) ? st_data_frame
                                      : st_nothing_rx;
        else if (v_sdf || v_sbf || v_sif || v_edf)
        begin
          st_d   = st_nothing_rx;
          ferr_d = 1'b1;
        end
      default:
        st_d = st_nothing_rx;
    endcase
    if (flush_req)
      st_d = st_nothing_rx;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      st_q <= st_nothing_rx;
    else
      st_q <= st_d;
  end

  // Error strobes, one cycle each
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      crc_err_pulse   <= 1'b0;
      frame_err_pulse <= 1'b0;
    end
    else
    begin
      crc_err_pulse   <= crc_bad;
      frame_err_pulse <= ferr_d && !flush_req;
    end
  end

  // Tag each data word with the frame it belongs to
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      class_out <= '0;
    else
    begin
      class_out.valid <= v_data;
      case (st_q)
        st_idle_frame:    class_out.cls <= cls_idle;
        st_data_frame:    class_out.cls <= cls_data;
        st_bcast_frame:   class_out.cls <= cls_bcast;
        st_bcast_in_data: class_out.cls <= cls_bcast;
        default:          class_out.cls <= cls_none;
      endcase
    end
  end

  assign rx_state = st_q;

  // ----------------------------------------------------------------
  // Data frame buffer
  // ----------------------------------------------------------------
  logic [31:0]      dbuf [DBUF_DEPTH];
  logic [DBUF_AW:0] dwr_q;
  logic             dovf_q;
  logic [DBUF_AW:0] dlen_q;
  logic [DBUF_AW:0] drd_q;
  logic             drain_q;
  logic             accept_df;

  // Overflowed frames are dropped rather than handed up truncated
  assign accept_df = in_dframe && v_edf && !abort && !dovf_q &&
                     !flush_req;

  always_ff @(posedge clk)
  begin
    if (sys_rst || flush_req)
    begin
      dwr_q  <= '0;
      dovf_q <= 1'b0;
    end
    else if (v_sdf || enter_nothing)
    begin
      dwr_q  <= '0;
      dovf_q <= 1'b0;
    end
    else if (in_dframe && v_data)
    begin
      if (dwr_q == (DBUF_AW+1)'(DBUF_DEPTH))
        dovf_q <= 1'b1;
      else
      begin
        dbuf[dwr_q[DBUF_AW-1:0]] <= rx_in.word;
        dwr_q <= dwr_q + 1'b1;
      end
    end
  end

  // Drain runs from its own length copy, so the flush on leaving the
  // frame does not cut it. A frame accepted mid-drain restarts it.
  always_ff @(posedge clk)
  begin
    if (sys_rst || flush_req)
    begin
      drain_q <= 1'b0;
      drd_q   <= '0;
      dlen_q  <= '0;
    end
    else if (accept_df)
    begin
      drain_q <= (dwr_q != '0);
      drd_q   <= '0;
      dlen_q  <= dwr_q;
    end
    else if (drain_q)
    begin
      drd_q <= drd_q + 1'b1;
      if (drd_q == dlen_q - 1'b1)
        drain_q <= 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      df_out <= '0;
    else
    begin
      df_out.valid <= drain_q && !flush_req;
      df_out.last  <= drain_q && (drd_q == dlen_q - 1'b1);
      // Word moves only while draining, so idle cycles never show
      // unwritten buffer entries
      if (drain_q)
        df_out.word <= dbuf[drd_q[DBUF_AW-1:0]];
    end
  end

  // ----------------------------------------------------------------
  // Broadcast frame buffer
  // ----------------------------------------------------------------
  logic [31:0] bbuf [BC_WORDS];
  logic        accept_bc;

  assign accept_bc = in_bframe && v_ebf && !abort && !flush_req &&
                     (bcnt_q == BC_WORDS);

  // Counter saturates so that any longer frame stays refused
  always_ff @(posedge clk)
  begin
    if (sys_rst || flush_req)
      bcnt_q <= '0;
    else if (v_sbf || enter_nothing)
      bcnt_q <= '0;
    else if (in_bframe && v_data)
    begin
      if (bcnt_q < BC_WORDS)
        bbuf[bcnt_q[0]] <= rx_in.word;
      if (bcnt_q != BC_CNT_MAX)
        bcnt_q <= bcnt_q + 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      bc_out <= '0;
    else
    begin
      bc_out.valid    <= accept_bc;
      if (accept_bc)
      begin
        bc_out.words[0] <= bbuf[0];
        bc_out.words[1] <= bbuf[1];
      end
    end
  end

  // ----------------------------------------------------------------
  // Control words, taken in any state
  // ----------------------------------------------------------------
  logic ctrl_take;

  always_comb
  begin
    ctrl_take = 1'b0;
    if (rx_in.valid)
      case (rx_in.kind)
        flow_credit_token: ctrl_take = ctrl_crc_ok && seq_ok;
        ack_word:          ctrl_take = ctrl_crc_ok;
        nack_word:         ctrl_take = ctrl_crc_ok;
        full_word:         ctrl_take = ctrl_crc_ok;
        retry_word:        ctrl_take = 1'b1;
        default:           ctrl_take = 1'b0;
      endcase
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      ctrl_out <= '0;
    else
    begin
      ctrl_out.valid <= ctrl_take && !flush_req;
      ctrl_out.kind  <= rx_in.kind;
      ctrl_out.word  <= rx_in.word;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_idle_entry: assert property (@(posedge clk) disable iff (sys_rst)
    (st_q == st_nothing_rx && v_sif && !flush_req)
    |=> st_q == st_idle_frame) else $error("idle entry missed");
  a_idle_retry: assert property (@(posedge clk) disable iff (sys_rst)
    (st_q == st_idle_frame && (v_retry || lane_rx_error))
    |=> st_q == st_nothing_rx) else $error("idle exit missed");
  a_idle_ferr: assert property (@(posedge clk) disable iff (sys_rst)
    (st_q == st_idle_frame && (v_edf || v_ebf) && !lane_rx_error &&
     !flush_req) |=> frame_err_pulse && st_q == st_nothing_rx)
    else $error("idle frame error missed");
  a_idle_sbf: assert property (@(posedge clk) disable iff (sys_rst)
    (st_q == st_idle_frame && v_sbf && !lane_rx_error && !flush_req)
    |=> st_q == st_bcast_frame) else $error("idle to bcast");
  a_ctrl_take: assert property (@(posedge clk) disable iff (sys_rst)
    (rx_in.valid && rx_in.kind == ack_word && ctrl_crc_ok && !flush_req)
    |=> ctrl_out.valid && ctrl_out.kind == ack_word)
    else $error("control word dropped");
  a_df_release: assert property (@(posedge clk) disable iff (sys_rst)
    (accept_df && dwr_q != '0) ##1 !flush_req
    |=> df_out.valid) else $error("data frame not released");
  a_bc_two: assert property (@(posedge clk) disable iff (sys_rst)
    bc_out.valid |-> $past(bcnt_q) == BC_WORDS)
    else $error("broadcast released with wrong count");
  a_flush_empty: assert property (@(posedge clk) disable iff (sys_rst)
    flush_req |=> dwr_q == '0 && bcnt_q == '0 && !drain_q &&
    st_q == st_nothing_rx) else $error("flush left data");
  a_nothing_flush: assert property (@(posedge clk) disable iff (sys_rst)
    (st_q != st_nothing_rx ##1 st_q == st_nothing_rx)
    |-> dwr_q == '0 && bcnt_q == '0) else $error("no flush");
  a_crc_strobe: assert property (@(posedge clk) disable iff (sys_rst)
    (d_crc_bad && !flush_req) |=> crc_err_pulse &&
    st_q == st_nothing_rx ##1 !crc_err_pulse)
    else $error("checksum strobe wrong");
  a_bid_back: assert property (@(posedge clk) disable iff (sys_rst)
    (st_q == st_bcast_in_data && v_ebf && !abort && !flush_req &&
     bcnt_q == BC_WORDS) |=> st_q == st_data_frame)
    else $error("nested broadcast return");

endmodule

//--- tb/lane_src.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Lane layer word source
// ----------------------------------------------------------------
module lane_src
  import rx_frame_pkg::*;
(
  input  wire logic clk,
  output lane_word_t rx_in
);
  logic [15:0] c16;
  logic [7:0]  c8;
  logic        in_bc;

  // Frame checksum step, low bit of byte 0 entered first
  function automatic logic [15:0] f16(logic [15:0] c, logic [31:0] d,
                                      int n);
    for (int i = 0; i < n; i++)
      c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? 16'h1021 : 16'h0000);
    return c;
  endfunction

  // Short checksum step, zero preset, x^8 + x^2 + x + 1
  function automatic logic [7:0] f8(logic [7:0] c, logic [31:0] d, int n);
    for (int i = 0; i < n; i++)
      c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
    return c;
  endfunction

  initial
  begin
    rx_in = '0;
    in_bc = 1'b0;
  end

  // One word per call; bad flips one checksum bit on purpose
  task automatic put(word_kind_t k, logic [31:0] w, logic bad = 1'b0);
    logic [7:0] t;
    if (k == data_start_word)
      c16 = f16(16'hFFFF, w, 32);
    if (k == bcast_start_word)
      c8 = f8(8'h00, w, 32);
    if (k == data_word && in_bc)
      c8 = f8(c8, w, 32);
    if (k == data_word && !in_bc)
      c16 = f16(c16, w, 32);
    if (k == data_end_word)
      w[31:16] = f16(c16, w, 16) ^ {15'h0000, bad};
    if (k inside {bcast_end_word, flow_credit_token, ack_word, nack_word,
                  full_word})
    begin
      t = f8((k == bcast_end_word) ? c8 : 8'h00, w, 24);
      w[31:24] = {<<{t}};
      w[24] = w[24] ^ bad;
    end
    if (k inside {bcast_end_word, retry_word, data_start_word})
      in_bc = 1'b0;
    if (k == bcast_start_word)
      in_bc = 1'b1;
    rx_in = {1'b1, k, w};
    @(negedge clk);
  endtask

  // Released word toggles so a stale value is never mistaken for data
  task automatic idle;
    rx_in.valid = 1'b0;
    rx_in.word = ~rx_in.word;
    @(negedge clk);
  endtask
endmodule

//--- tb/tb.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Receive frame checker bench
// ----------------------------------------------------------------
module tb;
  import rx_frame_pkg::*;
  logic       clk, sys_rst, lane_rx_error, seq_ok;
  logic       warm_reset_req, remote_flush_req;
  logic       crc_err_pulse, frame_err_pulse;
  lane_word_t rx_in;
  df_out_t    df_out;
  bc_out_t    bc_out;
  ctrl_out_t  ctrl_out;
  class_out_t class_out;
  rx_state_t  rx_state;
  int         err_count, tests_run;

  lane_src src (.clk(clk), .rx_in(rx_in));

  rx_frame_check_crc uut (
    .clk(clk), .sys_rst(sys_rst), .rx_in(rx_in),
    .lane_rx_error(lane_rx_error), .seq_ok(seq_ok),
    .warm_reset_req(warm_reset_req), .remote_flush_req(remote_flush_req),
    .df_out(df_out), .bc_out(bc_out), .ctrl_out(ctrl_out),
    .class_out(class_out), .crc_err_pulse(crc_err_pulse),
    .frame_err_pulse(frame_err_pulse), .rx_state(rx_state));

  // Bench clock, 8 ns period
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic chk(logic [63:0] got, logic [63:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Clean two-word data frame, drained one word per cycle
  task automatic t_data;
    src.put(data_start_word, 32'h0000_00FC);
    chk(rx_state, st_data_frame);
    src.put(data_word, 32'hA5A5_0001);
    chk(class_out, {1'b1, cls_data});
    src.put(data_word, 32'h0000_00FD);
    src.put(data_end_word, 32'h0000_01FC);
    chk(crc_err_pulse, 1'b0);
    chk(rx_state, st_nothing_rx);
    src.idle;
    chk(df_out, {2'b10, 32'hA5A5_0001});
    src.idle;
    chk(df_out, {2'b11, 32'h0000_00FD});
    $display("data frame test done");
  endtask

  // Broadcast of n words; only two words may pass upward
  task automatic t_bcast(int n, logic bad = 1'b0);
    src.put(bcast_start_word, 32'h0000_01FC);
    chk(rx_state, st_bcast_frame);
    for (int i = 0; i < n; i++)
    begin
      src.put(data_word, 32'hB000_0000 + i);
      chk(class_out, {1'b1, cls_bcast});
    end
    src.put(bcast_end_word, 32'h0002_05FC, bad);
    chk(bc_out.valid, n == 2 && !bad);
    chk(crc_err_pulse, bad);
    if (n == 2 && !bad)
      chk(bc_out.words, {32'hB000_0001, 32'hB000_0000});
    $display("broadcast test done");
  endtask

  // Broadcast nested inside a data frame
  task automatic t_nest;
    src.put(data_start_word, 32'h0000_00FC);
    src.put(data_word, 32'hA5A5_0002);
    src.put(bcast_start_word, 32'h0000_01FC);
    chk(rx_state, st_bcast_in_data);
    src.put(data_word, 32'hB000_0000);
    src.put(data_word, 32'hB000_0001);
    src.put(bcast_end_word, 32'h0003_05FC);
    chk(rx_state, st_data_frame);
    chk(bc_out.valid, 1'b1);
    src.put(retry_word, 32'h0000_0AFC);
    chk(rx_state, st_nothing_rx);
    $display("nested broadcast test done");
  endtask

  // Every exit of the idle-frame state
  task automatic t_idle;
    word_kind_t k [7];
    rx_state_t  s [7];
    k = '{retry_word, data_word, data_end_word, bcast_end_word,
          bcast_start_word, data_start_word, idle_start_word};
    s = '{st_nothing_rx, st_nothing_rx, st_nothing_rx, st_nothing_rx,
          st_bcast_frame, st_data_frame, st_idle_frame};
    for (int i = 0; i < 7; i++)
    begin
      src.put(idle_start_word, 32'h0000_00FC);
      chk(rx_state, st_idle_frame);
      src.put(data_word, 32'h0000_1234);
      chk(class_out, {1'b1, cls_idle});
      lane_rx_error = (i == 1);
      src.put(k[i], 32'h0000_02FC);
      lane_rx_error = 1'b0;
      chk(rx_state, s[i]);
      chk(frame_err_pulse, i inside {2, 3});
      src.put(retry_word, 32'h0000_0AFC);
    end
    $display("idle state test done");
  endtask

  // Control words accepted mid-frame; bad checksum or order refused
  task automatic t_ctrl;
    word_kind_t k [5];
    k = '{flow_credit_token, ack_word, nack_word, full_word, retry_word};
    src.put(data_start_word, 32'h0000_00FC);
    for (int i = 0; i < 5; i++)
    begin
      src.put(k[i], 32'h0004_03FC);
      chk(ctrl_out.valid, 1'b1);
      chk(ctrl_out.kind, k[i]);
      chk(ctrl_out.word[23:0], 24'h04_03FC);
    end
    src.put(ack_word, 32'h0004_03FC, 1'b1);
    chk(ctrl_out.valid, 1'b0);
    seq_ok = 1'b0;
    src.put(flow_credit_token, 32'h0004_03FC);
    seq_ok = 1'b1;
    chk(ctrl_out.valid, 1'b0);
    $display("control word test done");
  endtask

  // Bad checksum, then out-of-sequence end word: nothing forwarded
  task automatic t_err;
    for (int j = 0; j < 2; j++)
    begin
      src.put(data_start_word, 32'h0000_00FC);
      src.put(data_word, 32'hC000_0001);
      seq_ok = (j == 0);
      src.put(data_end_word, 32'h0000_01FC, j == 0);
      seq_ok = 1'b1;
      chk(crc_err_pulse, j == 0);
      chk(rx_state, st_nothing_rx);
      src.idle;
      chk(crc_err_pulse, 1'b0);
      chk(df_out.valid, 1'b0);
    end
    $display("error frame test done");
  endtask

  // Warm reset, remote flush and retry each empty a half-built frame
  task automatic t_flush;
    for (int j = 0; j < 3; j++)
    begin
      src.put(data_start_word, 32'h0000_00FC);
      src.put(data_word, 32'hD000_0000);
      warm_reset_req = (j == 0);
      remote_flush_req = (j == 1);
      if (j == 2)
        src.put(retry_word, 32'h0000_0AFC);
      else
        src.idle;
      warm_reset_req = 1'b0;
      remote_flush_req = 1'b0;
      chk(rx_state, st_nothing_rx);
      src.put(data_start_word, 32'h0000_00FC);
      src.put(data_word, 32'hD000_0001);
      src.put(data_end_word, 32'h0000_01FC);
      src.idle;
      chk(df_out, {2'b11, 32'hD000_0001});
    end
    $display("flush test done");
  endtask

  // Main sequence
  initial
  begin
    sys_rst = 1'b1;
    lane_rx_error = 1'b0;
    seq_ok = 1'b1;
    warm_reset_req = 1'b0;
    remote_flush_req = 1'b0;
    err_count = 0;
    tests_run = 0;
    repeat (4) @(posedge clk);
    @(negedge clk);
    sys_rst = 1'b0;
    chk(rx_state, st_nothing_rx);
    src.idle;
    chk(df_out, '0);
    chk(bc_out.words, '0);
    t_data;
    t_bcast(2);
    t_bcast(3);
    t_bcast(1);
    t_bcast(2, 1'b1);
    t_nest;
    t_idle;
    t_ctrl;
    t_err;
    t_flush;
    test_done;
  end

  // Watchdog, well beyond the hundred or so cycles the tests need
  initial
  begin
    repeat (2000) @(posedge clk);
    err_count++;
    test_done;
  end
endmodule
